//--- verilog/srxcr_defines.svh
// Register offsets, field positions, reset values and counts of the receive lane
`ifndef SRXCR_DEFINES_SVH
`define SRXCR_DEFINES_SVH
`define SRX_CTRL_OFS   4'h0
`define SRX_STAT_OFS   4'h4
`define SRX_F_OC       0
`define SRX_F_ALGO     1
`define SRX_F_WIDTH    4
`define SRX_F_ALIGN    7
`define SRX_RST_OC     1'h1
`define SRX_RST_ALGO   3'h6
`define SRX_RST_WIDTH  3'h2
`define SRX_RST_ALIGN  2'h0
`define SRX_W20        3'h2
`define SRX_W16        3'h3
`define SRX_AL_OFF     2'h0
`define SRX_AL_COMMA   2'h1
`define SRX_AL_JOG     2'h2
`define SRX_ALGO_ECO   3'h7
`define SRX_SETTLE_WIN 5'h03
`define SRX_ECO_WIN    5'h0c
`define SRX_ACC_MAX    9'h0ff
`define SRX_ACC_MIN    9'h101
`define SRX_JOG_MAX    15
`endif

//--- verilog/srxcr_pkg.sv
// Types shared by the receive lane modules
package srxcr_pkg;
  typedef enum logic [2:0] {
    ALN_IDLE = 3'h1,
    ALN_WAIT = 3'h2,
    ALN_LOCK = 3'h4
  } srxcr_aln_e;

  typedef struct packed {
    logic       last;
    logic [3:0] early;
    logic [3:0] late;
    logic       valid;
  } srxcr_vote_s;

  typedef struct packed {
    logic [19:0] prev;
    logic [4:0]  off;
    logic        msb;
    logic [19:0] word;
    srxcr_aln_e  st;
  } srxcr_aln_s;

  typedef struct packed {
    logic               ack;
    logic        [31:0] rdat;
    logic               oc;
    logic        [2:0]  algo;
    logic        [2:0]  width;
    logic        [1:0]  align;
    logic signed [4:0]  cnt;
    logic signed [8:0]  acc;
    logic        [9:0]  nco;
    logic        [4:0]  blank;
    logic               step;
    logic               dir;
    logic               pend;
    logic               pdir;
  } srxcr_core_s;
endpackage

//--- verilog/srxcr_lane_if.sv
// Signals between the lane core, the voter and the aligner
`timescale 1ns/1ps
interface srxcr_lane_if;
  logic        win_valid;
  logic        win_late;
  logic        win_early;
  logic [2:0]  width;
  logic [1:0]  align_sel;
  logic [19:0] word;
  logic        lock;
  modport vote_src (output win_valid, win_late, win_early);
  modport aln (input width, align_sel, output word, lock);
endinterface

//--- verilog/srxcr_vote.sv
// Early/late voter over one twelve-bit window
`timescale 1ns/1ps
module srxcr_vote (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // Samples, bit 0 earliest
  input  wire logic        smp_valid_i,
  input  wire logic [11:0] data_smp_i,
  input  wire logic [11:0] phase_smp_i,
  // Window result
  srxcr_lane_if.vote_src   vote
);
  srxcr_pkg::srxcr_vote_s s_q;
  srxcr_pkg::srxcr_vote_s s_d;
  logic                   first;

  // Last bit of the previous window pairs with bit 0, giving twelve comparisons
  always_comb begin
    s_d = s_q;
    first = s_q.last;
    s_d.valid = smp_valid_i;
    if (smp_valid_i) begin
      s_d.early = 4'h0;
      s_d.late = 4'h0;
      for (int i = 0; i < 12; i++) begin
        if (first != data_smp_i[i]) begin
          if (phase_smp_i[i] == first) begin
            s_d.early = s_d.early + 4'h1;
          end else begin
            s_d.late = s_d.late + 4'h1;
          end
        end
        first = data_smp_i[i];
      end
      s_d.last = data_smp_i[11];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign vote.win_valid = s_q.valid;
  assign vote.win_late  = s_q.late > s_q.early;
  assign vote.win_early = s_q.early > s_q.late;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_no_edge;
    smp_valid_i && data_smp_i == {12{s_q.last}} |=> !vote.win_late && !vote.win_early;
  endproperty
  a_no_edge: assert property (p_no_edge) else $error("Vote without transition");

  property p_window;
    smp_valid_i |=> vote.win_valid && ({1'b0, s_q.early} + {1'b0, s_q.late} <= 5'h0c);
  endproperty
  a_window: assert property (p_window) else $error("Window result wrong");
endmodule // srxcr_vote

//--- verilog/srxcr_align.sv
// Deserializer word select with comma alignment at 20-bit width and single-bit jog
`timescale 1ns/1ps
`include "srxcr_defines.svh"
module srxcr_align (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // Recovered bits, MSB earliest
  input  wire logic [19:0] rx_bits_i,
  // Settings and aligned word
  srxcr_lane_if.aln        lane
);
  localparam int JogMax = `SRX_JOG_MAX;
  srxcr_pkg::srxcr_aln_s s_q;
  srxcr_pkg::srxcr_aln_s s_d;
  logic [39:0]           strm;
  logic [19:0]           sel;
  logic [4:0]            hit_pos;
  logic                  hit;
  logic                  aligned;
  logic                  jog;
  logic                  w16;
  logic                  realign;

  function automatic logic is_comma(input logic [6:0] b);
    return (b == 7'h1f) || (b == 7'h60);
  endfunction

  always_comb begin
    s_d = s_q;
    realign = 1'b0;
    w16 = lane.width == `SRX_W16;
    strm = w16 ? {s_q.prev[15:0], rx_bits_i[15:0], 8'h00} : {s_q.prev, rx_bits_i};
    sel = strm[39 - s_q.off -: 20];
    s_d.word = w16 ? {4'h0, sel[19:4]} : sel;
    hit = 1'b0;
    hit_pos = 5'h00;
    for (int p = 19; p >= 0; p--) begin
      if (is_comma(strm[39 - p -: 7])) begin
        hit = 1'b1;
        hit_pos = 5'(p);
      end
    end
    aligned = hit_pos == s_q.off || hit_pos == s_q.off + 5'h0a || s_q.off == hit_pos + 5'h0a;
    jog = lane.align_sel == `SRX_AL_JOG && !s_q.msb;
    s_d.msb = lane.align_sel[1];
    s_d.prev = rx_bits_i;
    case (lane.align_sel)
      `SRX_AL_COMMA: begin
        if (lane.width == `SRX_W20 && hit && !aligned) begin
          s_d.off = hit_pos;
          realign = 1'b1;
        end
      end
      `SRX_AL_JOG: begin
        if (jog) begin
          s_d.off = (s_q.off >= (w16 ? 5'h0f : 5'h13)) ? 5'h00 : s_q.off + 5'h01;
          realign = 1'b1;
        end
      end
      default: realign = 1'b0;
    endcase
    case (s_q.st)
      srxcr_pkg::ALN_IDLE: s_d.st = realign ? srxcr_pkg::ALN_WAIT : srxcr_pkg::ALN_IDLE;
      srxcr_pkg::ALN_WAIT: s_d.st = realign ? srxcr_pkg::ALN_WAIT : srxcr_pkg::ALN_LOCK;
      srxcr_pkg::ALN_LOCK: s_d.st = realign ? srxcr_pkg::ALN_WAIT : srxcr_pkg::ALN_IDLE;
      default:             s_d.st = srxcr_pkg::ALN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{st: srxcr_pkg::ALN_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign lane.word = s_q.word;
  assign lane.lock = s_q.st == srxcr_pkg::ALN_LOCK;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_off_hold;
    lane.align_sel == `SRX_AL_OFF |=> s_q.off == $past(s_q.off);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("Realigned while disabled");

  property p_comma_w;
    lane.align_sel == `SRX_AL_COMMA && lane.width != `SRX_W20 |=> $stable(s_q.off);
  endproperty
  a_comma_w: assert property (p_comma_w) else $error("Comma realign off width");

  property p_jog_lock;
    jog |-> ##[1:JogMax] lane.lock;
  endproperty
  a_jog_lock: assert property (p_jog_lock) else $error("Jog did not lock in time");

  property p_w16;
    lane.width == `SRX_W16 |=> s_q.word[19:16] == 4'h0;
  endproperty
  a_w16: assert property (p_w16) else $error("16-bit word has upper bits");
endmodule // srxcr_align

//--- verilog/srxcr_top.sv
// Receive lane back end: clock recovery loops, register slave, alignment
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "srxcr_defines.svh"
module srxcr_top (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Samples, one voting window per valid
  input  wire logic        smp_valid_i,
  input  wire logic [11:0] data_smp_i,
  input  wire logic [11:0] phase_smp_i,
  // Recovered bits, MSB earliest
  input  wire logic [19:0] rx_bits_i,
  // Analog controls
  output logic             offset_comp_enable_o,
  output logic             phase_step_o,
  output logic             phase_dir_o,
  // Parallel side
  output logic      [19:0] rx_word_o,
  output logic             rx_lock_o
);
  localparam srxcr_pkg::srxcr_core_s RstVal = '{
    oc:      `SRX_RST_OC,
    algo:    `SRX_RST_ALGO,
    width:   `SRX_RST_WIDTH,
    align:   `SRX_RST_ALIGN,
    default: '0
  };

  // One instance per lane; nothing is shared between lanes
  srxcr_pkg::srxcr_core_s s_q;
  srxcr_pkg::srxcr_core_s s_d;
  logic        [3:0]       thr;
  logic signed [5:0]       cnt_n;
  logic        [5:0]       mag;
  logic        [7:0]       acc_mag;
  logic        [10:0]      nco_n;
  logic                    f_go;
  logic                    f_dir;
  logic                    s_go;
  logic                    s_dir;
  logic                    req;
  logic                    wr_ctrl;

  srxcr_lane_if lane ();

  srxcr_vote u_vote (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .smp_valid_i (smp_valid_i),
    .data_smp_i  (data_smp_i),
    .phase_smp_i (phase_smp_i),
    .vote        (lane.vote_src)
  );

  srxcr_align u_align (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .rx_bits_i (rx_bits_i),
    .lane      (lane.aln)
  );

  function automatic logic [3:0] vote_thr(input logic [2:0] a);
    case (a)
      3'h0, 3'h4: vote_thr = 4'hf;
      3'h1, 3'h7: vote_thr = 4'h7;
      3'h2, 3'h5: vote_thr = 4'h3;
      default:    vote_thr = 4'h1;
    endcase
  endfunction

  assign req = wb_cyc_i & wb_stb_i;
  assign wr_ctrl = req & wb_we_i & s_q.ack & ({wb_adr_i[3:2], 2'b00} == `SRX_CTRL_OFS);

  always_comb begin
    s_d = s_q;
    thr = vote_thr(s_q.algo);
    cnt_n = {s_q.cnt[4], s_q.cnt};
    mag = 6'h00;
    f_go = 1'b0;
    f_dir = 1'b0;
    s_go = 1'b0;
    s_dir = !s_q.acc[8];
    acc_mag = s_q.acc[8] ? 8'(-s_q.acc) : s_q.acc[7:0];
    nco_n = {1'b0, s_q.nco} + {3'h0, acc_mag};

    // Registered ack: one wait state, dropped the cycle after it is given
    s_d.ack = req & ~s_q.ack;
    if (s_d.ack) begin
      case ({wb_adr_i[3:2], 2'b00})
        `SRX_CTRL_OFS: s_d.rdat = {23'h0, s_q.align, s_q.width, s_q.algo, s_q.oc};
        `SRX_STAT_OFS: s_d.rdat = {11'h0, s_q.cnt, 7'h0, s_q.acc};
        default:       s_d.rdat = 32'h0;
      endcase
    end

    if (lane.win_valid) begin
      if (s_q.blank != 5'h00) begin
        s_d.blank = s_q.blank - 5'h01;
      end else begin
        if (lane.win_late) begin
          cnt_n = cnt_n + 6'h01;
        end else if (lane.win_early) begin
          cnt_n = cnt_n - 6'h01;
        end
        mag = cnt_n[5] ? 6'(-cnt_n) : cnt_n;
        // First order runs the same whether or not the second order is on
        if (mag >= {2'b00, thr}) begin
          f_go = 1'b1;
          f_dir = !cnt_n[5];
          cnt_n = 6'h00;
          // Only first order steps blank; second order steps come too often
          s_d.blank = (s_q.algo == `SRX_ALGO_ECO) ?
                      `SRX_SETTLE_WIN + `SRX_ECO_WIN : `SRX_SETTLE_WIN;
        end
        s_d.cnt = cnt_n[4:0];
      end
      if (!s_q.algo[2]) begin
        if (f_go && f_dir && s_q.acc != `SRX_ACC_MAX) begin
          s_d.acc = s_q.acc + 9'h001;
        end else if (f_go && !f_dir && s_q.acc != `SRX_ACC_MIN) begin
          s_d.acc = s_q.acc - 9'h001;
        end
        // 10-bit phase accumulator: full scale 255 steps once per ~4 windows
        s_go = nco_n[10];
        s_d.nco = nco_n[9:0];
      end
    end

    // Step goes out on the edge after the window result; coinciding opposite steps cancel, a same-way second order step waits one edge
    s_d.step = 1'b0;
    if (f_go) begin
      s_d.step = !(s_go && s_dir != f_dir);
      s_d.dir = f_dir;
      if (s_go && s_dir == f_dir) begin
        s_d.pend = 1'b1;
        s_d.pdir = s_dir;
      end
    end else if (s_q.pend) begin
      s_d.step = 1'b1;
      s_d.dir = s_q.pdir;
      s_d.pend = s_go;
      s_d.pdir = s_dir;
    end else if (s_go) begin
      s_d.step = 1'b1;
      s_d.dir = s_dir;
    end

    if (wr_ctrl) begin
      if (wb_sel_i[0]) begin
        s_d.oc = wb_dat_i[`SRX_F_OC];
        s_d.algo = wb_dat_i[`SRX_F_ALGO +: 3];
        s_d.width = wb_dat_i[`SRX_F_WIDTH +: 3];
        s_d.align[0] = wb_dat_i[`SRX_F_ALIGN];
      end
      if (wb_sel_i[1]) begin
        s_d.align[1] = wb_dat_i[`SRX_F_ALIGN + 1];
      end
      if (s_d.algo != s_q.algo) begin
        s_d.cnt = 5'h00;
        s_d.acc = 9'h000;
        s_d.nco = 10'h000;
        s_d.blank = 5'h00;
        s_d.pend = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= RstVal;
    end else begin
      s_q <= s_d;
    end
  end

  assign lane.width = s_q.width;
  assign lane.align_sel = s_q.align;
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign offset_comp_enable_o = s_q.oc;
  assign phase_step_o = s_q.step;
  assign phase_dir_o = s_q.dir;
  assign rx_word_o = lane.word;
  assign rx_lock_o = lane.lock;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_oc;
    wr_ctrl && wb_sel_i[0] |=> offset_comp_enable_o == $past(wb_dat_i[0]);
  endproperty
  a_oc: assert property (p_oc) else $error("Offset enable not written");

  property p_cnt_up;
    lane.win_valid && s_q.blank == 5'h00 && lane.win_late && !f_go && !wr_ctrl
      |=> s_q.cnt == $past(s_q.cnt) + 5'h01;
  endproperty
  a_cnt_up: assert property (p_cnt_up) else $error("Counter missed late vote");

  property p_thr;
    lane.win_valid && s_q.blank == 5'h00 && s_q.algo[2] && lane.win_late
      && s_q.cnt == 5'(vote_thr(s_q.algo) - 4'h1)
      |=> phase_step_o && phase_dir_o && s_q.cnt == 5'h00;
  endproperty
  a_thr: assert property (p_thr) else $error("No step at threshold");

  property p_settle;
    f_go && !wr_ctrl |=> s_q.blank >= `SRX_SETTLE_WIN;
  endproperty
  a_settle: assert property (p_settle) else $error("Settle windows not set");

  property p_ignore;
    lane.win_valid && s_q.blank != 5'h00 && !wr_ctrl |=> $stable(s_q.cnt);
  endproperty
  a_ignore: assert property (p_ignore) else $error("Blanked window counted");

  property p_acc_dn;
    f_go && !f_dir && !s_q.algo[2] && s_q.acc != `SRX_ACC_MIN && !wr_ctrl
      |=> s_q.acc == $past(s_q.acc) - 9'h001;
  endproperty
  a_acc_dn: assert property (p_acc_dn) else $error("Accumulator missed early");

  property p_so_step;
    s_go && !f_go && !s_q.pend |=> phase_step_o && phase_dir_o == !$past(s_q.acc[8]);
  endproperty
  a_so_step: assert property (p_so_step) else $error("Second order step lost");

  property p_sat;
    s_q.acc == `SRX_ACC_MAX && f_go && f_dir && !wr_ctrl |=> s_q.acc == `SRX_ACC_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("Accumulator wrapped");

  property p_clr;
    wr_ctrl && wb_sel_i[0] && wb_dat_i[3:1] != s_q.algo
      |=> s_q.cnt == 5'h00 && s_q.acc == 9'h000;
  endproperty
  a_clr: assert property (p_clr) else $error("Loops not cleared");

  property p_ack;
    req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("Bus answer late");
endmodule // srxcr_top

//--- verification/srxcr_tx_model.sv
// Remote transmitter model: vote samples and the recovered symbol stream
`timescale 1ns/1ps
module srxcr_tx_model (
  // Clock
  input  wire logic        ref_clk_i,
  // Stream control
  input  wire logic [1:0]  kind_i,
  input  wire logic [19:0] word_i,
  // Lane side
  output logic      [11:0] data_smp_o,
  output logic      [11:0] phase_smp_o,
  output logic      [19:0] rx_bits_o
);
  // Kind 0 steady line, 1 late, 2 early; every pattern ends high so windows chain
  assign data_smp_o  = (kind_i == 2'h0) ? 12'hfff : 12'haaa;
  assign phase_smp_o = (kind_i == 2'h2) ? 12'h555 : data_smp_o;
  // A periodic stream repeats one word, so a boundary shift is a plain rotation
  always_ff @(posedge ref_clk_i) begin
    rx_bits_o <= word_i;
  end
endmodule // srxcr_tx_model

//--- verification/testbench.sv
// Self-checking bench for the receive lane back end
`timescale 1ns/1ps
module testbench;
  localparam logic [19:0] ALN = 20'h3eaaa;
  logic        ref_clk_i, rstn_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic        smp_valid, oc_en, step, dir, rx_lock;
  logic [3:0]  wb_adr, wb_sel;
  logic [31:0] wb_dat, wb_rdat, rd;
  logic [1:0]  kind;
  logic [19:0] word, rx_bits, rx_word;
  logic [11:0] dsmp, psmp;
  int          errors, cmp_count, steps, s0, n;
  int          thr[8] = '{15, 7, 3, 1, 15, 3, 1, 7};

  srxcr_top DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .smp_valid_i(smp_valid),
    .data_smp_i(dsmp), .phase_smp_i(psmp), .rx_bits_i(rx_bits),
    .offset_comp_enable_o(oc_en), .phase_step_o(step), .phase_dir_o(dir),
    .rx_word_o(rx_word), .rx_lock_o(rx_lock));
  srxcr_tx_model u_tx (.ref_clk_i(ref_clk_i), .kind_i(kind), .word_i(word),
    .data_smp_o(dsmp), .phase_smp_o(psmp), .rx_bits_o(rx_bits));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (step === 1'b1) steps++;
  end

  function automatic logic [19:0] rotl(logic [19:0] x, int k);
    return (x << k) | (x >> (20 - k));
  endfunction

  function automatic logic [31:0] ctl(logic [2:0] algo, logic [1:0] al, logic [2:0] w);
    return {23'h0, al, w, algo, 1'b1};
  endfunction

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Classic cycle: held until ack is sampled, released right after
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (k >= 50) chk("wb_ack", 32'h0, 32'h1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // Separate windows leave room for the step pulse to be counted
  task automatic win(logic [1:0] k, int cnt);
    repeat (cnt) begin
      @(posedge ref_clk_i);
      kind <= k;
      smp_valid <= 1'b1;
      @(posedge ref_clk_i);
      smp_valid <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask

  task automatic burst(logic [1:0] k, int cnt);
    @(posedge ref_clk_i);
    kind <= k;
    smp_valid <= 1'b1;
    repeat (cnt) @(posedge ref_clk_i);
    smp_valid <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask

  task automatic wait_word(logic [19:0] exp);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rx_word !== exp && n < 60);
    chk("rx_word", rx_word, exp);
  endtask

  initial begin
    rstn_i = 1'b0;
    {wb_cyc, wb_stb, wb_we, smp_valid} = 4'h0;
    wb_adr = 4'h0;
    wb_dat = 32'h0;
    kind = 2'h0;
    word = rotl(ALN, 3);
    wb_sel = 4'hf;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl_reset", rd, 32'h2d);
    chk("oc_en", oc_en, 32'h1);
    wb(1'b0, 4'h8, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, 4'h0, 32'h2c);
    @(posedge ref_clk_i);
    chk("oc_off", oc_en, 32'h0);
    // Low byte lane only: the upper alignment bit must stay clear
    wb_sel <= 4'h1;
    wb(1'b1, 4'h0, 32'h12c);
    wb_sel <= 4'hf;
    wb(1'b0, 4'h0, 32'h0);
    chk("sel_mask", rd, 32'h2c);
    $display("test registers done");

    chk("word_20", rx_word, rotl(ALN, 3));
    wb(1'b1, 4'h0, ctl(3'h6, 2'h1, 3'h3));
    repeat (4) @(posedge ref_clk_i);
    chk("word_16", rx_word, {16'h0, ALN[12:0], ALN[19:17]});
    wb(1'b1, 4'h0, ctl(3'h6, 2'h1, 3'h2));
    wait_word(ALN);
    word <= rotl(~ALN, 5);
    wait_word(~ALN);
    wb(1'b1, 4'h0, ctl(3'h6, 2'h0, 3'h2));
    word <= rotl(ALN, 2);
    repeat (60) @(posedge ref_clk_i);
    chk("no_align", rx_word, rotl(ALN, 17));
    wb(1'b1, 4'h0, ctl(3'h6, 2'h2, 3'h2));
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rx_lock !== 1'b1 && n < 16);
    chk("jog_lock", rx_lock, 32'h1);
    chk("jog_word", rx_word, rotl(ALN, 18));
    @(posedge ref_clk_i);
    chk("lock_pulse", rx_lock, 32'h0);
    $display("test alignment done");

    // Voter leaves reset with a low last bit, so a first steady window votes late once;
    // spend that vote here, the code change below clears the loops again
    win(2'h0, 1);

    for (int c = 0; c < 8; c++) begin
      wb(1'b1, 4'h0, ctl(c[2:0], 2'h0, 3'h2));
      win(2'h0, 16);
      s0 = steps;
      win(2'h1, thr[c] - 1);
      win(2'h0, 1);
      wb(1'b0, 4'h4, 32'h0);
      chk("counter", rd[20:16], thr[c] - 1);
      chk("early_step", steps, s0);
      win(2'h1, 1);
      chk("late_step", steps, s0 + 1);
      chk("late_dir", dir, 32'h1);
      wb(1'b0, 4'h4, 32'h0);
      chk("acc", rd[8:0], (c < 4) ? 32'h1 : 32'h0);
      chk("cnt_clr", rd[20:16], 32'h0);
      win(2'h2, ((c == 7) ? 15 : 3) + thr[c] - 1);
      chk("blanked", steps, s0 + 1);
      win(2'h2, 1);
      chk("early_step", steps, s0 + 2);
      chk("early_dir", dir, 32'h0);
    end
    $display("test first order done");

    wb(1'b1, 4'h0, ctl(3'h3, 2'h0, 3'h2));
    burst(2'h1, 1200);
    wb(1'b0, 4'h4, 32'h0);
    chk("acc_sat", rd[8:0], 32'hff);
    s0 = steps;
    burst(2'h0, 40);
    chk("nco_rate", (steps - s0 >= 9) && (steps - s0 <= 10), 32'h1);
    chk("nco_dir", dir, 32'h1);
    wb(1'b1, 4'h4, 32'hffffffff);
    wb(1'b1, 4'h0, ctl(3'h6, 2'h0, 3'h2));
    wb(1'b0, 4'h4, 32'h0);
    chk("cleared", rd & 32'h1f01ff, 32'h0);
    $display("test second order done");
    print_verdict();
  end

  // Whole run needs about 3100 cycles
  initial begin
    #1_000_000;
    errors++;
    print_verdict();
  end
endmodule // testbench
